// ==== src/isep_pkg.sv ====
// Purpose: Shared constants for the interrupt service and external pin block
// Assumes: AXI4-Lite register access, 32-bit data, one register per word
// Notes:   Registers are 8 bits wide in the low byte of each word
package isep_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_TIMER_EXT_INT_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_PRIO_LOW_BITS = 8'h8c;
    localparam logic [7:0] ADDR_PRIO_HIGH_BITS = 8'h90;
    localparam logic [7:0] ADDR_SRC_ENABLE = 8'h94;
    localparam logic [7:0] ADDR_SERVICE_STATUS = 8'h98;
    // Field positions inside timer_ext_int_control
    localparam int BIT_TYPE0 = 0;
    localparam int BIT_FLAG0 = 1;
    localparam int BIT_TYPE1 = 2;
    localparam int BIT_FLAG1 = 3;
    // Type select encodings
    localparam logic TYPE_LEVEL = 1'b0;
    localparam logic TYPE_EDGE = 1'b1;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RST_PIN = 2'b11;
    // Injected call length in clocks
    localparam logic [2:0] CALL_CYCLES = 3'h4;
    // Vector generation
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } isep_state_t;
endpackage : isep_pkg

// ==== src/isep_top.sv ====
// Purpose: Interrupt poll, priority resolve, call injection, ext pins
// Assumes: Core signals are on aclk; pins are asynchronous
// Notes:   Source 0 and 1 are the external pins, lower index wins ties
`timescale 1ns/100ps

// Functional notes
// - Sample and resolve all request flags every clock, same cycle.
// - No call while equal or higher level is in service.
// - Call only on the last cycle of the running instruction.
// - No call during RETI or writes to enable or priority bits.
// - Blocked requests are not remembered; each poll uses current flags.
// - Core pushes PC without status word and jumps to vector.
// - RETI pops PC and ends the current service level.
// - Plain RET restores PC but keeps the service level marked.
// - Injected call lasts 4 clocks, 5 from flag to routine.
// - Single-interrupt response never exceeds 16 clocks.
// - Edge mode: high sample then low sample sets pin flag.
// - Edge flag clears on entry, else stays until software clears.
// - Level mode flag equals inverted pin, read-only, not cleared.
// - Bit 0 and bit 2 select type: 0 level, 1 falling edge.
// - Pin request flags sit at bits 1 and 3.
// - Either pin request wakes the device from power-down.
// - Two-bit priority per source, higher level preempts lower.
// - Equal level ties go to higher natural priority.
module isep_top
    import isep_pkg::*;
#(
    parameter int NSRC = 8
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_pin0,
    input wire logic ext_irq_pin1,
    input wire logic [NSRC-1:2] periph_req,
    input wire logic instr_last,
    input wire logic instr_blocks,
    input wire logic instr_reti,
    input wire logic instr_ret,
    input wire logic power_down,
    output logic call_start,
    output logic call_active,
    output logic [15:0] call_vector,
    output logic wake
);
    localparam int SW = $clog2(NSRC);

    typedef struct packed {
        logic [1:0] sync0;
        logic [1:0] sync1;
        logic [1:0] prev;
        logic [3:0] timer_ext_int_control_hi;
        logic [1:0] type_sel;
        logic [1:0] eflag;
        logic [NSRC-1:0] lo;
        logic [NSRC-1:0] hi;
        logic [NSRC-1:0] en;
        logic [3:0] isv;
        isep_state_t st;
        logic [2:0] cnt;
        logic [15:0] vec;
        logic start;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic wake;
    } isep_regs_t;

    isep_regs_t s;
    isep_regs_t next_s;

    logic [1:0] pin_lvl;
    logic [1:0] fall;
    logic [1:0] ext_flag;
    logic [NSRC-1:0] pend;
    logic found;
    logic [SW-1:0] sel;
    logic [1:0] best_lvl;
    logic isv_any;
    logic [1:0] isv_top;
    logic take;
    logic wr_en;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    assign pin_lvl = s.sync1;
    assign fall = s.prev & ~s.sync1;
    assign ext_flag = (s.type_sel & s.eflag) |
        (~s.type_sel & ~pin_lvl);
    assign pend = {periph_req, ext_flag} & s.en;
    // Highest level first, lowest index inside a level
    always_comb
    begin
        found = 1'b0;
        sel = '0;
        best_lvl = 2'b00;
        for (int i = 0; i < NSRC; i++)
        begin
            if (pend[i] && (!found || {s.hi[i], s.lo[i]} > best_lvl))
            begin
                found = 1'b1;
                sel = SW'(i);
                best_lvl = {s.hi[i], s.lo[i]};
            end
        end
    end

    always_comb
    begin
        isv_any = |s.isv;
        isv_top = 2'b00;
        for (int l = 0; l < 4; l++)
        begin
            if (s.isv[l])
                isv_top = 2'(l);
        end
    end

    assign take = (s.st == ST_IDLE) && found && instr_last &&
        !instr_blocks && !instr_reti &&
        (!isv_any || best_lvl > isv_top);

    // AXI decode
    assign wr_en = s.aw_got && s.w_got && !s.bvalid;
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            ADDR_TIMER_EXT_INT_CONTROL:
                rd_val = {s.timer_ext_int_control_hi, ext_flag[1], s.type_sel[1],
                    ext_flag[0], s.type_sel[0]};
            ADDR_PRIO_LOW_BITS: rd_val = 8'(s.lo);
            ADDR_PRIO_HIGH_BITS: rd_val = 8'(s.hi);
            ADDR_SRC_ENABLE: rd_val = 8'(s.en);
            ADDR_SERVICE_STATUS: rd_val = {3'h0, s.st == ST_CALL, s.isv};
            default:
            begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end
    assign wr_ok = s.awaddr inside {ADDR_TIMER_EXT_INT_CONTROL,
        ADDR_PRIO_LOW_BITS, ADDR_PRIO_HIGH_BITS, ADDR_SRC_ENABLE,
        ADDR_SERVICE_STATUS};

    always_comb
    begin
        next_s = s;
        next_s.sync0 = {ext_irq_pin1, ext_irq_pin0};
        next_s.sync1 = s.sync0;
        next_s.prev = s.sync1;
        next_s.start = 1'b0;
        next_s.wake = power_down && (|ext_flag);

        // Edge flags: hardware set wins over any clear
        for (int i = 0; i < 2; i++)
        begin
            if (s.type_sel[i] != TYPE_EDGE)
                next_s.eflag[i] = 1'b0;
            else if (fall[i])
                next_s.eflag[i] = 1'b1;
            else if (take && sel == SW'(i))
                next_s.eflag[i] = 1'b0;
            else if (wr_en && s.wstrb0 &&
                s.awaddr == ADDR_TIMER_EXT_INT_CONTROL)
                next_s.eflag[i] = s.wdata[i == 0 ? BIT_FLAG0 : BIT_FLAG1];
        end

        if (wr_en && s.wstrb0)
        begin
            unique case (s.awaddr)
                ADDR_TIMER_EXT_INT_CONTROL:
                begin
                    next_s.timer_ext_int_control_hi = s.wdata[7:4];
                    next_s.type_sel = {s.wdata[BIT_TYPE1],
                        s.wdata[BIT_TYPE0]};
                end
                ADDR_PRIO_LOW_BITS: next_s.lo = NSRC'(s.wdata);
                ADDR_PRIO_HIGH_BITS: next_s.hi = NSRC'(s.wdata);
                ADDR_SRC_ENABLE: next_s.en = NSRC'(s.wdata);
                default: next_s.en = s.en;
            endcase
        end

        // In-service markers; RET leaves them alone
        if (instr_reti && isv_any)
            next_s.isv[isv_top] = 1'b0;
        if (take)
            next_s.isv[best_lvl] = 1'b1;

        unique case (s.st)
            ST_IDLE:
            begin
                if (take)
                begin
                    next_s.st = ST_CALL;
                    next_s.cnt = CALL_CYCLES - 3'h1;
                    next_s.start = 1'b1;
                    next_s.vec = VEC_BASE + 16'(sel) * VEC_STEP;
                end
            end
            ST_CALL:
            begin
                if (s.cnt == 3'h0)
                    next_s.st = ST_IDLE;
                else
                    next_s.cnt = s.cnt - 3'h1;
            end
            default: next_s.st = ST_IDLE;
        endcase

        // AXI write path
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_en)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;

        // AXI read path
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_val;
            next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;

        if (!aresetn)
        begin
            next_s = '0;
            next_s.st = ST_IDLE;
            next_s.sync0 = RST_PIN;
            next_s.sync1 = RST_PIN;
            next_s.prev = RST_PIN;
            next_s.lo = NSRC'(RST_REG);
            next_s.hi = NSRC'(RST_REG);
            next_s.en = NSRC'(RST_REG);
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready = !s.w_got && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = {24'h000000, s.rdata};
    assign s_axi_rresp = s.rresp;
    assign call_start = s.start;
    assign call_active = (s.st == ST_CALL);
    assign call_vector = s.vec;
    assign wake = s.wake;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    call_gate_a: assert property (take |-> instr_last)
        else $error("call injected outside last instruction cycle");
    call_block_a: assert property (take |-> !instr_blocks && !instr_reti)
        else $error("call injected during blocking instruction");
    prio_block_a: assert property (take && isv_any |-> best_lvl > isv_top)
        else $error("call injected under equal or higher service");
    call_len_a: assert property (take |=> call_active [*4] ##1 !call_active)
        else $error("injected call not four cycles long");
    no_latch_a: assert property (!s.type_sel[0] |=> !s.eflag[0])
        else $error("level request left a stored flag");
    edge_set_a: assert property (s.type_sel[0] && fall[0]
        |=> s.eflag[0])
        else $error("falling edge did not set pin 0 flag");
    level_follow_a: assert property (!s.type_sel[1]
        |-> ext_flag[1] == !pin_lvl[1])
        else $error("level flag does not follow inverted pin");
    entry_clear_a: assert property (take && sel == '0 && s.type_sel[0]
        && !fall[0] |=> !s.eflag[0])
        else $error("edge flag not cleared on entry");
    reti_clear_a: assert property (instr_reti && isv_any && !take
        |=> $countones(s.isv) == $countones($past(s.isv)) - 1)
        else $error("return did not release one service level");
    ret_keep_a: assert property (instr_ret && !instr_reti && !take
        |=> s.isv == $past(s.isv))
        else $error("plain return changed service levels");
    vec_out_a: assert property (take |=> call_start &&
        call_vector == VEC_BASE + 16'($past(sel)) * VEC_STEP)
        else $error("vector does not match granted source");

    call_seen_c: cover property (take);
    preempt_c: cover property (take && isv_any);
    reti_c: cover property (instr_reti && isv_any);
    edge_c: cover property (fall[1] && s.type_sel[1]);
endmodule : isep_top

// ==== tb/isep_core_model.sv ====
// Purpose: Behavioural core sequencer facing the interrupt block
// Assumes: One-clock instructions, or three-clock ones when slow
// Notes:   No instruction ends while the injected call runs
`timescale 1ns/100ps
module isep_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic blocks,
    input wire logic reti_req,
    input wire logic ret_req,
    input wire logic call_active,
    output logic instr_last,
    output logic instr_blocks,
    output logic instr_reti,
    output logic instr_ret
);
    logic [1:0] phase;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || call_active || phase == 2'h2)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    assign instr_last = !call_active && (!slow || phase == 2'h2);
    assign instr_blocks = blocks && instr_last;
    assign instr_reti = reti_req && instr_last;
    assign instr_ret = ret_req && instr_last;
endmodule : isep_core_model

// ==== tb/isep_top_tb_top.sv ====
// Purpose: Self-checking bench for the interrupt service block
// Assumes: Core model answers every clock unless slow is set
// Notes:   Pin changes need two clocks to reach a level flag, three to set an edge flag
`timescale 1ns/100ps
module isep_top_tb_top
    import isep_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic pin0 = 1'b1, pin1 = 1'b1, pdown = 1'b0;
    logic slow = 1'b0, blocks = 1'b0, reti_q = 1'b0, ret_q = 1'b0;
    logic [7:2] preq = 6'h00;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, data;
    logic last, blk, reti, ret, cstart, cact, wake;
    logic [15:0] cvec;
    int failures = 0;
    int compares = 0;

    isep_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_irq_pin0(pin0), .ext_irq_pin1(pin1), .periph_req(preq),
        .instr_last(last), .instr_blocks(blk), .instr_reti(reti),
        .instr_ret(ret), .power_down(pdown), .call_start(cstart),
        .call_active(cact), .call_vector(cvec), .wake(wake));

    isep_core_model u_core (.aclk(aclk), .aresetn(aresetn), .slow(slow),
        .blocks(blocks), .reti_req(reti_q), .ret_req(ret_q),
        .call_active(cact), .instr_last(last), .instr_blocks(blk),
        .instr_reti(reti), .instr_ret(ret));

    always #2 aclk = ~aclk;

    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic final_report();
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Extra edge at the end keeps back-to-back calls from double driving
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        resp = rresp;
        chk("rdata", rdata, e);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rt();
        reti_q <= 1'b1;
        @(posedge aclk);
        reti_q <= 1'b0;
        @(posedge aclk);
    endtask : rt

    task automatic exp_call(input logic [15:0] v);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (cstart !== 1'b1 && n < 60);
        // Counted from the call of this task, never before activation
        chk("latency", 32'(n <= 16), 32'h1);
        chk("vector", 32'(cvec), 32'(v));
        n = 0;
        while (cact === 1'b1)
        begin
            n++;
            @(negedge aclk);
        end
        chk("call_len", 32'(n), 32'h4);
        @(posedge aclk);
    endtask : exp_call

    task automatic no_call(input int n);
        int k;
        k = 0;
        repeat (n)
        begin
            @(negedge aclk);
            if (cstart !== 1'b0) k++;
        end
        chk("no_call", 32'(k), 32'h0);
        @(posedge aclk);
    endtask : no_call

    initial
    begin
        #80000;
        failures++;
        final_report();
    end

    initial
    begin
        cyc(20);
        aresetn <= 1'b1;
        cyc(1);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h0);
        rd(ADDR_SERVICE_STATUS, 32'h0);
        rd(8'hfc, 32'h0);
        chk("rresp", 32'(resp), 32'(RESP_SLVERR));
        wr(8'hfc, 32'h1);
        chk("bresp", 32'(resp), 32'(RESP_SLVERR));
        pin0 <= 1'b0;
        cyc(8);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h02);
        wr(ADDR_TIMER_EXT_INT_CONTROL, 32'h0);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h02);
        pdown <= 1'b1;
        cyc(3);
        chk("wake", 32'(wake), 32'h1);
        pdown <= 1'b0;
        pin0 <= 1'b1;
        cyc(8);
        chk("wake_off", 32'(wake), 32'h0);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h0);
        wr(ADDR_TIMER_EXT_INT_CONTROL, 32'h05);
        pin1 <= 1'b0;
        cyc(8);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h0d);
        wr(ADDR_TIMER_EXT_INT_CONTROL, 32'h05);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h05);
        pin1 <= 1'b1;
        wr(ADDR_SRC_ENABLE, 32'h03);
        pin0 <= 1'b0;
        exp_call(16'h0003);
        rd(ADDR_TIMER_EXT_INT_CONTROL, 32'h05);
        rd(ADDR_SERVICE_STATUS, 32'h01);
        pin1 <= 1'b0;
        no_call(20);
        ret_q <= 1'b1;
        cyc(1);
        ret_q <= 1'b0;
        no_call(10);
        rt();
        exp_call(16'h000b);
        rt();
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        rd(ADDR_SERVICE_STATUS, 32'h0);
        wr(ADDR_PRIO_LOW_BITS, 32'h02);
        wr(ADDR_PRIO_HIGH_BITS, 32'h02);
        pin0 <= 1'b0;
        exp_call(16'h0003);
        pin1 <= 1'b0;
        exp_call(16'h000b);
        rd(ADDR_SERVICE_STATUS, 32'h09);
        rt();
        rd(ADDR_SERVICE_STATUS, 32'h01);
        rt();
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        wr(ADDR_PRIO_LOW_BITS, 32'h0);
        wr(ADDR_PRIO_HIGH_BITS, 32'h0);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        exp_call(16'h0003);
        rt();
        exp_call(16'h000b);
        rt();
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        blocks <= 1'b1;
        slow <= 1'b1;
        cyc(4);
        pin0 <= 1'b0;
        no_call(20);
        blocks <= 1'b0;
        exp_call(16'h0003);
        slow <= 1'b0;
        rt();
        pin0 <= 1'b1;
        wr(ADDR_TIMER_EXT_INT_CONTROL, 32'h04);
        blocks <= 1'b1;
        pin0 <= 1'b0;
        cyc(8);
        pin0 <= 1'b1;
        cyc(8);
        blocks <= 1'b0;
        no_call(20);
        pin0 <= 1'b0;
        exp_call(16'h0003);
        rt();
        exp_call(16'h0003);
        pin0 <= 1'b1;
        cyc(4);
        rt();
        wr(ADDR_SRC_ENABLE, 32'h07);
        preq <= 6'h01;
        exp_call(16'h0013);
        preq <= 6'h00;
        rt();
        rd(ADDR_SERVICE_STATUS, 32'h0);
        final_report();
    end
endmodule : isep_top_tb_top
